// file: adcc_analog_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------
// Analog inputs seen through the channel multiplexer
// ---------------------------------------------------------------------
module adcc_analog_model
  import adcc_pkg::*;
#(
  parameter logic [RES_W-1:0] REF_LEVEL = 8'h2E
)
(
  input  wire logic [CHS_W-1:0] mux_channel_i,
  input  wire logic             mux_ext_i,
  input  wire logic [RES_W-1:0] dac_trial_i,
  output logic                  cmp_o,
  output logic                  osc_tick_o
);
  logic [RES_W-1:0] level;

  // Each external pin holds its own level; code F is the fixed reference.
  // Reserved codes read as ground, so a stray select shows up as zero.
  always_comb begin
    if (mux_ext_i) begin
      level = 8'h1B + 8'h25 * {5'h00, mux_channel_i[2:0]};
    end else if (mux_channel_i == CHS_FIXREF) begin
      level = REF_LEVEL;
    end else begin
      level = 8'h00;
    end
    cmp_o = (level >= dac_trial_i);
  end

  // The internal oscillator runs free and unrelated to the system clock.
  initial begin
    osc_tick_o = 1'b0;
    forever #40 osc_tick_o = ~osc_tick_o;
  end
endmodule

// file: adcc_clkdiv.sv
`timescale 1ns/1ps
module adcc_clkdiv
  import adcc_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                run_i,
  input  wire logic                osc_tick_i,
  input  wire logic [CLKSEL_W-1:0] sel_i,
  output logic                     tick_o
);

  logic [DIV_W-1:0] cnt_r;
  logic [DIV_W-1:0] cnt_nxt;
  logic             tick_r;
  logic             tick_nxt;
  logic             src;

  // ---------------------------------------------------------------------
  // Divider
  // ---------------------------------------------------------------------
  // Counts source ticks; the oscillator setting counts oscillator ticks.
  always_comb begin
    src      = (sel_i == CLKSEL_OSC4) ? osc_tick_i : 1'b1;
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (!run_i) begin
      cnt_nxt = '0;
    end else if (src) begin
      if (cnt_r == adcc_divisor(sel_i) - 5'h01) begin
        cnt_nxt  = '0;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_o = tick_r;

endmodule

// file: adcc_monitor.sv
`timescale 1ns/1ps
module adcc_monitor
  import adcc_pkg::*;
(
  input wire logic                clk_i,
  input wire logic                rst_n_i,
  input wire logic                go_set_i,
  input wire logic                go_clr_i,
  input wire logic                flag_clr_i,
  input wire logic                int_en_i,
  input wire logic                sleep_i,
  input wire logic                go_done_o,
  input wire logic                converter_enable_o,
  input wire logic [CLKSEL_W-1:0] conv_clock_select_o,
  input wire logic [CHS_W-1:0]    input_channel_select_o,
  input wire logic [ANS_W-1:0]    analog_pin_select_o,
  input wire logic [CHS_W-1:0]    mux_channel_o,
  input wire logic [ANS_W-1:0]    pin_oe_o,
  input wire logic                conv_complete_flag_o,
  input wire logic                irq_o,
  input wire logic [RES_W-1:0]    conv_result_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  logic [9:0]          cnt_r;
  logic [9:0]          cnt_nxt;
  logic [CLKSEL_W-1:0] sel_r;
  logic [CLKSEL_W-1:0] sel_nxt;
  logic [9:0]          lo;

  // Busy length and the clock select seen in the first busy cycle.
  always_comb begin
    cnt_nxt = go_done_o ? cnt_r + 10'h001 : 10'h000;
    sel_nxt = (go_done_o && cnt_r == 10'h000) ? conv_clock_select_o : sel_r;
    lo = (sel_r == CLKSEL_DIV16) ? 10'h0CF :
         (sel_r == CLKSEL_DIV8) ? 10'h067 : 10'h033;
  end

  // Registers only; the bound allows a few cycles of handshake latency.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_r <= 10'h000;
      sel_r <= CLKSEL_RST;
    end else begin
      cnt_r <= cnt_nxt;
      sel_r <= sel_nxt;
    end
  end

  chk_conv_length: assert property (
    $rose(conv_complete_flag_o) && sel_r != CLKSEL_OSC4
    |-> cnt_r >= lo && cnt_r <= lo + 10'h004)
    else $error("conversion length wrong");
  chk_flag_on_done: assert property (
    $rose(conv_complete_flag_o) |-> $fell(go_done_o))
    else $error("flag set without completion");
  chk_flag_sticky: assert property (
    $fell(conv_complete_flag_o) |-> $past(flag_clr_i))
    else $error("flag dropped by itself");
  chk_irq_gate: assert property (
    !$past(int_en_i) |-> !irq_o)
    else $error("request while disabled");
  chk_start_gate: assert property (
    $rose(go_done_o) |-> $past(go_set_i) && $past(converter_enable_o)
    && !$past(sleep_i))
    else $error("illegal start");
  chk_pin_oe_mask: assert property (
    (pin_oe_o & analog_pin_select_o) == '0)
    else $error("driver on analog pin");
  chk_sleep_defaults: assert property (
    $rose(sleep_i) && go_done_o |-> ##1 !go_done_o && !converter_enable_o
    && conv_clock_select_o == CLKSEL_RST
    && input_channel_select_o == CHS_RST)
    else $error("sleep entry state wrong");
  chk_mux_hold: assert property (
    go_done_o && $past(go_done_o) && $past(go_done_o, 2)
    |-> $stable(mux_channel_o))
    else $error("channel moved in conversion");
  chk_abort_keeps: assert property (
    go_done_o && go_clr_i |=> !go_done_o && !$rose(conv_complete_flag_o)
    ##2 $stable(conv_result_o)[*3])
    else $error("abort misbehaved");
  chk_reset_pins: assert property (
    $rose(rst_n_i) |-> analog_pin_select_o == ANS_RST)
    else $error("pin select reset wrong");
endmodule

bind adcc_top adcc_monitor mon (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .go_set_i(go_set_i),
  .go_clr_i(go_clr_i), .flag_clr_i(flag_clr_i), .int_en_i(int_en_i),
  .sleep_i(sleep_i), .go_done_o(go_done_o),
  .converter_enable_o(converter_enable_o),
  .conv_clock_select_o(conv_clock_select_o),
  .input_channel_select_o(input_channel_select_o),
  .analog_pin_select_o(analog_pin_select_o),
  .mux_channel_o(mux_channel_o), .pin_oe_o(pin_oe_o),
  .conv_complete_flag_o(conv_complete_flag_o), .irq_o(irq_o),
  .conv_result_o(conv_result_o)
);

// file: adcc_pkg.sv
package adcc_pkg;

  // ---------------------------------------------------------------------
  // Field widths and reset values
  // ---------------------------------------------------------------------
  localparam int unsigned RES_W          = 8;
  localparam int unsigned ANS_W          = 8;
  localparam int unsigned CHS_W          = 4;
  localparam int unsigned CLKSEL_W       = 2;
  localparam logic [ANS_W-1:0]    ANS_RST    = 8'hFF;
  localparam logic [CHS_W-1:0]    CHS_RST    = 4'hF;
  localparam logic [CLKSEL_W-1:0] CLKSEL_RST = 2'h0;
  localparam logic [RES_W-1:0]    RES_RST    = 8'h00;

  // ---------------------------------------------------------------------
  // Clock select codes and divisors
  // ---------------------------------------------------------------------
  localparam logic [CLKSEL_W-1:0] CLKSEL_DIV16 = 2'h0;
  localparam logic [CLKSEL_W-1:0] CLKSEL_DIV8  = 2'h1;
  localparam logic [CLKSEL_W-1:0] CLKSEL_DIV4  = 2'h2;
  localparam logic [CLKSEL_W-1:0] CLKSEL_OSC4  = 2'h3;
  localparam int unsigned DIV_W      = 5;
  localparam logic [DIV_W-1:0] DIV16 = 5'h10;
  localparam logic [DIV_W-1:0] DIV8  = 5'h08;
  localparam logic [DIV_W-1:0] DIV4  = 5'h04;

  // ---------------------------------------------------------------------
  // Conversion timing in conversion clock periods
  // ---------------------------------------------------------------------
  localparam int unsigned TAD_W          = 4;
  localparam logic [TAD_W-1:0] TAD_TOTAL = 4'hD;
  localparam logic [TAD_W-1:0] TAD_SHIFT0 = 4'h4;
  localparam int unsigned SHIFT_COUNT    = 9;

  // ---------------------------------------------------------------------
  // Channel codes
  // ---------------------------------------------------------------------
  localparam logic [CHS_W-1:0] CHS_EXT_MAX = 4'h7;
  localparam logic [CHS_W-1:0] CHS_FIXREF  = 4'hF;

  // Software control bundle.
  typedef struct packed {
    logic                converter_enable;
    logic [CLKSEL_W-1:0] conv_clock_select;
    logic [CHS_W-1:0]    input_channel_select;
    logic [ANS_W-1:0]    analog_pin_select;
  } adcc_ctrl_t;

  // Status bundle returned to software.
  typedef struct packed {
    logic                busy;
    logic                conv_complete_flag;
    logic [RES_W-1:0]    conv_result;
  } adcc_stat_t;

  typedef enum logic [1:0] {
    ADCC_IDLE,
    ADCC_SAMPLE,
    ADCC_CONVERT
  } adcc_state_t;

  // Maps a clock select code onto its divisor.
  function automatic logic [DIV_W-1:0] adcc_divisor(
    input logic [CLKSEL_W-1:0] sel
  );
    unique case (sel)
      CLKSEL_DIV16: adcc_divisor = DIV16;
      CLKSEL_DIV8:  adcc_divisor = DIV8;
      CLKSEL_DIV4:  adcc_divisor = DIV4;
      CLKSEL_OSC4:  adcc_divisor = DIV4;
    endcase
  endfunction

endpackage

// file: adcc_sar.sv
`timescale 1ns/1ps
module adcc_sar
  import adcc_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             clear_i,
  input  wire logic             step_i,
  input  wire logic             cmp_i,
  output logic [RES_W-1:0]      trial_o,
  output logic [RES_W-1:0]      result_o,
  output logic                  done_o
);

  // Shift register holds only the leading one; res_r holds the decided bits.
  logic [RES_W:0] sh_r;
  logic [RES_W:0] sh_nxt;
  logic [RES_W-1:0] res_r;
  logic [RES_W-1:0] res_nxt;

  // ---------------------------------------------------------------------
  // Successive approximation
  // ---------------------------------------------------------------------
  // Each step decides the bit under the leading one, then shifts it right.
  always_comb begin
    sh_nxt  = sh_r;
    res_nxt = res_r;
    if (clear_i) begin
      sh_nxt  = {1'b1, {RES_W{1'b0}}};
      res_nxt = '0;
    end else if (step_i && sh_r != '0) begin
      if (sh_r[RES_W:1] != '0) begin
        res_nxt = res_r | (cmp_i ? sh_r[RES_W:1] : '0);
      end
      sh_nxt = sh_r >> 1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sh_r  <= '0;
      res_r <= RES_RST;
    end else begin
      sh_r  <= sh_nxt;
      res_r <= res_nxt;
    end
  end

  assign trial_o  = res_r | sh_r[RES_W:1];
  assign result_o = res_r;
  assign done_o   = (sh_r == '0);

endmodule

// file: adcc_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Each conversion yields an unsigned 8-bit result.
// - Clock sources: divide by 16, 8, 4, oscillator/4.
// - A conversion lasts exactly thirteen clock periods.
// - Divisor changes period length, not period count.
// - Clock select changes apply at next start.
// - Sleep entry returns clock select to default.
// - Conversion clock divides the instruction clock; select 11 divides the oscillator instead.
// - Any reset sets analog pin select to ones.
// - Analog-selected pins have digital drivers disabled.
// - Analog pin select acts regardless of enable.
// - Channel changes apply after current conversion.
// - Sleep entry returns channel select to default.
// - Status bit starts; completion clears, sets flag.
// - Clearing status bit aborts, keeps partial result.
// - Sleep clears status bit and halts conversion.
// - Start ignored while converter enable is clear.
// - Select codes: 00/16, 01/8, 10/4, 11/osc4.
// - Clear, shift leading one MSB first, nine shifts.
// - Codes 0-7 external channels, 1111 reference.
// - Sleep during conversion also clears enable.
module adcc_top
  import adcc_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  input  wire adcc_ctrl_t          ctrl_i,
  input  wire logic                ctrl_we_i,
  input  wire logic                go_set_i,
  input  wire logic                go_clr_i,
  input  wire logic                flag_clr_i,
  input  wire logic                int_en_i,
  input  wire logic                sleep_i,
  input  wire logic                osc_tick_i,
  input  wire logic                cmp_i,
  input  wire logic [ANS_W-1:0]    port_oe_i,
  output logic                     go_done_o,
  output logic                     converter_enable_o,
  output logic [CLKSEL_W-1:0]      conv_clock_select_o,
  output logic [CHS_W-1:0]         input_channel_select_o,
  output logic [ANS_W-1:0]         analog_pin_select_o,
  output logic [CHS_W-1:0]         mux_channel_o,
  output logic                     mux_ext_o,
  output logic                     sample_o,
  output logic [RES_W-1:0]         dac_trial_o,
  output logic [ANS_W-1:0]         pin_oe_o,
  output logic                     conv_complete_flag_o,
  output logic                     irq_o,
  output logic [RES_W-1:0]         conv_result_o
);

  // ---------------------------------------------------------------------
  // Input synchronisers for pin-side signals
  // ---------------------------------------------------------------------
  logic cmp_s1_r;
  logic cmp_s2_r;
  logic osc_s1_r;
  logic osc_s2_r;
  // The third stage only feeds the edge detector below.
  logic osc_s3_r;
  logic osc_tick;

  // The comparator answer reaches the SAR three clocks after the trial
  // word moves: one for the trial register, two for the synchroniser.
  // The fastest divisor gives four clocks per period, so the answer has
  // settled in time; a shorter period would need the SAR to wait longer.
  // Comparator and oscillator arrive from outside the clock domain.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cmp_s1_r <= 1'b0;
      cmp_s2_r <= 1'b0;
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
    end else begin
      cmp_s1_r <= cmp_i;
      cmp_s2_r <= cmp_s1_r;
      osc_s1_r <= osc_tick_i;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
    end
  end

  // Rising edge of the synchronised oscillator gives one source tick.
  assign osc_tick = osc_s2_r & ~osc_s3_r;

  // ---------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------
  logic                en_r;
  logic                en_nxt;
  logic [CLKSEL_W-1:0] csel_r;
  logic [CLKSEL_W-1:0] csel_nxt;
  logic [CHS_W-1:0]    chs_r;
  logic [CHS_W-1:0]    chs_nxt;
  logic [ANS_W-1:0]    ans_r;
  logic [ANS_W-1:0]    ans_nxt;
  logic                sleep_q_r;
  logic                sleep_entry;
  logic                busy;

  // Sleep entry is the first cycle of Sleep only, so a held level does
  // not keep reloading defaults over later software writes.
  assign sleep_entry = sleep_i & ~sleep_q_r;

  // Writes during a conversion land in the visible registers at once.
  // The sequencer keeps its own copies of clock and channel, so the
  // running conversion is not disturbed.
  // Sleep entry wins over a software write in the same cycle.
  always_comb begin
    en_nxt   = en_r;
    csel_nxt = csel_r;
    chs_nxt  = chs_r;
    ans_nxt  = ans_r;
    if (ctrl_we_i) begin
      en_nxt   = ctrl_i.converter_enable;
      csel_nxt = ctrl_i.conv_clock_select;
      chs_nxt  = ctrl_i.input_channel_select;
      ans_nxt  = ctrl_i.analog_pin_select;
    end
    if (sleep_entry) begin
      csel_nxt = CLKSEL_RST;
      chs_nxt  = CHS_RST;
      ans_nxt  = ANS_RST;
      if (busy) begin
        en_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      en_r      <= 1'b0;
      csel_r    <= CLKSEL_RST;
      chs_r     <= CHS_RST;
      ans_r     <= ANS_RST;
      sleep_q_r <= 1'b0;
    end else begin
      en_r      <= en_nxt;
      csel_r    <= csel_nxt;
      chs_r     <= chs_nxt;
      ans_r     <= ans_nxt;
      sleep_q_r <= sleep_i;
    end
  end

  // ---------------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------------
  adcc_state_t         st_r;
  adcc_state_t         st_nxt;
  logic                go_r;
  logic                go_nxt;
  logic                flag_r;
  logic                flag_nxt;
  logic [CLKSEL_W-1:0] act_sel_r;
  logic [CLKSEL_W-1:0] act_sel_nxt;
  logic [CHS_W-1:0]    act_chs_r;
  logic [CHS_W-1:0]    act_chs_nxt;
  logic [TAD_W-1:0]    tad_r;
  logic [TAD_W-1:0]    tad_nxt;
  logic                start;
  logic                abort;
  logic                tad_tick;
  logic                sar_clear;
  logic                sar_step;
  logic                sar_done;
  logic                finish;
  logic [RES_W-1:0]    sar_trial;
  logic [RES_W-1:0]    sar_result;

  assign busy  = (st_r != ADCC_IDLE);
  // A start needs the enable already set.
  assign start = go_set_i & en_r & ~busy & ~sleep_i;
  // Abort covers a software clear, Sleep, and the enable dropping.
  assign abort = busy & (go_clr_i | sleep_i | ~en_r);

  // Ticks of the divided conversion clock, held source per conversion.
  adcc_clkdiv u_clkdiv (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .run_i      (busy),
    .osc_tick_i (osc_tick),
    .sel_i      (act_sel_r),
    .tick_o     (tad_tick)
  );

  // Sampling occupies the first periods; the SAR then takes nine shifts.
  assign sar_clear = tad_tick & (st_r == ADCC_SAMPLE) &
                     (tad_r == TAD_SHIFT0 - 4'h1);
  assign sar_step  = tad_tick & (st_r == ADCC_CONVERT) & ~abort;
  assign finish    = tad_tick & (st_r == ADCC_CONVERT) &
                     (tad_r == TAD_TOTAL - 4'h1) & ~abort;

  adcc_sar u_sar (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .clear_i  (sar_clear),
    .step_i   (sar_step),
    .cmp_i    (cmp_s2_r),
    .trial_o  (sar_trial),
    .result_o (sar_result),
    .done_o   (sar_done)
  );

  // Periods 1 to 4 form the sampling phase; the fourth period tick clears
  // the result and loads the leading one. Periods 5 to 13 shift once each,
  // so the ninth shift lands on the thirteenth period and ends the run.
  // An abort blocks SAR steps, keeping the partial result; an abort on the fourth sampling tick still clears it.
  // Sequencer next state; the flag set beats a clear in the same cycle.
  always_comb begin
    st_nxt      = st_r;
    go_nxt      = go_r;
    tad_nxt     = tad_r;
    act_sel_nxt = act_sel_r;
    act_chs_nxt = act_chs_r;
    flag_nxt    = flag_r & ~flag_clr_i;
    unique case (st_r)
      ADCC_IDLE: begin
        // While idle the sampled channel follows the register, so the
        // multiplexer has settled before the next start.
        act_chs_nxt = chs_r;
        if (start) begin
          st_nxt      = ADCC_SAMPLE;
          go_nxt      = 1'b1;
          tad_nxt     = '0;
          act_sel_nxt = csel_r;
          act_chs_nxt = chs_r;
        end
      end
      ADCC_SAMPLE: begin
        if (abort) begin
          st_nxt = ADCC_IDLE;
          go_nxt = 1'b0;
        end else if (tad_tick) begin
          tad_nxt = tad_r + 4'h1;
          if (sar_clear) begin
            st_nxt = ADCC_CONVERT;
          end
        end
      end
      ADCC_CONVERT: begin
        if (abort) begin
          st_nxt = ADCC_IDLE;
          go_nxt = 1'b0;
        end else if (finish) begin
          st_nxt   = ADCC_IDLE;
          go_nxt   = 1'b0;
          flag_nxt = 1'b1;
        end else if (tad_tick) begin
          tad_nxt = tad_r + 4'h1;
        end
      end
      default: begin
        st_nxt = ADCC_IDLE;
        go_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r      <= ADCC_IDLE;
      go_r      <= 1'b0;
      flag_r    <= 1'b0;
      tad_r     <= '0;
      act_sel_r <= CLKSEL_RST;
      act_chs_r <= CHS_RST;
    end else begin
      st_r      <= st_nxt;
      go_r      <= go_nxt;
      flag_r    <= flag_nxt;
      tad_r     <= tad_nxt;
      act_sel_r <= act_sel_nxt;
      act_chs_r <= act_chs_nxt;
    end
  end

  // ---------------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------------
  logic [CHS_W-1:0] mux_r;
  logic             mux_ext_r;
  logic             sample_r;
  logic [RES_W-1:0] trial_r;
  logic [ANS_W-1:0] oe_r;
  logic             irq_r;
  logic [RES_W-1:0] res_r;

  // The mask uses the next select value, so a pin turns analog in the
  // same cycle as its select bit and never drives for a cycle too long.
  // Pin gating ignores the enable, so analog pins never drive digitally.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mux_r     <= CHS_RST;
      mux_ext_r <= 1'b0;
      sample_r  <= 1'b0;
      trial_r   <= RES_RST;
      oe_r      <= '0;
      irq_r     <= 1'b0;
      res_r     <= RES_RST;
    end else begin
      mux_r     <= act_chs_nxt;
      mux_ext_r <= (act_chs_nxt <= CHS_EXT_MAX);
      sample_r  <= (st_nxt == ADCC_SAMPLE);
      trial_r   <= sar_trial;
      oe_r      <= port_oe_i & ~ans_nxt;
      irq_r     <= flag_nxt & int_en_i;
      res_r     <= sar_result;
    end
  end

  // Unused SAR completion view kept for the leading-one idiom only.
  // The leading one leaves on the same edge as the final shift, so it
  // could only cross-check completion, never gate it.
  logic unused_done;
  assign unused_done = sar_done;

  // ---------------------------------------------------------------------
  // Output ports
  // ---------------------------------------------------------------------
  // Every port is a plain view of a register, with no logic in between.
  assign go_done_o              = go_r;
  assign converter_enable_o     = en_r;
  assign conv_clock_select_o    = csel_r;
  assign input_channel_select_o = chs_r;
  assign analog_pin_select_o    = ans_r;
  assign mux_channel_o          = mux_r;
  assign mux_ext_o              = mux_ext_r;
  assign sample_o               = sample_r;
  assign dac_trial_o            = trial_r;
  assign pin_oe_o               = oe_r;
  assign conv_complete_flag_o   = flag_r;
  assign irq_o                  = irq_r;
  assign conv_result_o          = res_r;

endmodule

// file: adcc_top_bench.sv
`timescale 1ns/1ps
module adcc_top_bench;
  import adcc_pkg::*;
  localparam logic [RES_W-1:0] REF_LVL = 8'h2E;
  logic clk_i = 1'b0, rst_n_i = 1'b0, ctrl_we_i = 1'b0, go_set_i = 1'b0;
  logic go_clr_i = 1'b0, flag_clr_i = 1'b0, int_en_i = 1'b0, sleep_i = 1'b0;
  logic osc_tick, cmp, go_done_o, en_o, mux_ext, flag_o, irq_o, samp;
  logic [ANS_W-1:0] port_oe_i = 8'h00, ans_o, pin_oe_o;
  logic [CLKSEL_W-1:0] sel_o;
  logic [CHS_W-1:0] chs_o, mux_ch;
  logic [RES_W-1:0] trial, res_o;
  adcc_ctrl_t ctrl_i = '0;
  int fail_count = 0;
  int compares = 0;

  // ---------------------------------------------------------------------
  // Design, analog side and clock
  // ---------------------------------------------------------------------
  adcc_top uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ctrl_i(ctrl_i),
    .ctrl_we_i(ctrl_we_i), .go_set_i(go_set_i), .go_clr_i(go_clr_i),
    .flag_clr_i(flag_clr_i), .int_en_i(int_en_i), .sleep_i(sleep_i),
    .osc_tick_i(osc_tick), .cmp_i(cmp), .port_oe_i(port_oe_i),
    .go_done_o(go_done_o), .converter_enable_o(en_o),
    .conv_clock_select_o(sel_o), .input_channel_select_o(chs_o),
    .analog_pin_select_o(ans_o), .mux_channel_o(mux_ch),
    .mux_ext_o(mux_ext), .sample_o(samp), .dac_trial_o(trial),
    .pin_oe_o(pin_oe_o), .conv_complete_flag_o(flag_o), .irq_o(irq_o),
    .conv_result_o(res_o));
  adcc_analog_model #(.REF_LEVEL(REF_LVL)) analog (.mux_channel_i(mux_ch),
    .mux_ext_i(mux_ext), .dac_trial_i(trial), .cmp_o(cmp),
    .osc_tick_o(osc_tick));
  always #12.5 clk_i = ~clk_i;

  // ---------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, exp, input string what);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  // Inputs move a fixed 2 ns after the edge, clear of sampling.
  task automatic tick();
    @(posedge clk_i);
    #2;
  endtask
  task automatic wr(input logic e, input logic [1:0] s, input logic [3:0] c,
                    input logic [7:0] a);
    ctrl_i = '{e, s, c, a};
    ctrl_we_i = 1'b1;
    tick();
    ctrl_we_i = 1'b0;
  endtask
  task automatic start();
    go_set_i = 1'b1;
    tick();
    go_set_i = 1'b0;
  endtask
  function automatic logic [7:0] lvl(input logic [3:0] c);
    // Reserved codes read as ground on the analog side.
    lvl = (c == CHS_FIXREF) ? REF_LVL :
          c[3] ? 8'h00 : 8'h1B + 8'h25 * {5'h00, c[2:0]};
  endfunction
  // Waits for completion, then checks length, result and the flag; skip
  // counts the busy cycles that the caller has already spent.
  task automatic finish(input logic [1:0] s, input logic [3:0] c,
                        input int skip);
    int n;
    int d;
    n = skip;
    d = (s == 2'h0) ? 16 : (s == 2'h1) ? 8 : 4;
    while (go_done_o === 1'b1 && n < 3000) begin
      tick();
      n++;
    end
    // Four 80 ns oscillator edges make a period of 12 or 13 clocks.
    if (s == 2'h3) check(n >= 156 && n <= 173, 1'b1, "osc");
    else check(n >= 13 * d - 1 && n <= 13 * d + 4, 1'b1, "length");
    tick();
    check(res_o, lvl(c), "result");
    check(flag_o, 1'b1, "flag");
    check(irq_o, int_en_i, "irq");
    flag_clr_i = 1'b1;
    tick();
    flag_clr_i = 1'b0;
    tick();
    check(flag_o, 1'b0, "flag clear");
  endtask
  task automatic t_convert(input logic [1:0] s, input logic [3:0] c);
    wr(1'b1, s, c, 8'hFF);
    repeat (4) tick();
    start();
    check({go_done_o, samp}, 2'b11, "busy");
    finish(s, c, 0);
  endtask

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_reset_pins_refused();
    check({ans_o, chs_o, sel_o, en_o, go_done_o}, 16'hFFF0, "reset");
    port_oe_i = 8'hFF;
    wr(1'b0, 2'h0, 4'hF, 8'h0F);
    tick();
    check(pin_oe_o, 8'hF0, "pin drivers");
    start();
    tick();
    check(go_done_o, 1'b0, "start while off");
  endtask
  task automatic t_midchange();
    wr(1'b1, CLKSEL_DIV4, 4'h2, 8'hFF);
    repeat (4) tick();
    start();
    repeat (10) tick();
    wr(1'b1, CLKSEL_DIV16, 4'h5, 8'hFF);
    finish(CLKSEL_DIV4, 4'h2, 11);
    start();
    finish(CLKSEL_DIV16, 4'h5, 0);
  endtask
  task automatic t_abort_sleep();
    t_convert(CLKSEL_DIV8, 4'h7);
    start();
    // Bits 7 to 4 of channel 7's level are decided before the abort lands.
    repeat (70) tick();
    go_clr_i = 1'b1;
    tick();
    go_clr_i = 1'b0;
    repeat (5) tick();
    check({go_done_o, flag_o, res_o}, {2'b00, 8'h10}, "abort");
    wr(1'b1, CLKSEL_DIV4, 4'h3, 8'h00);
    start();
    repeat (20) tick();
    sleep_i = 1'b1;
    repeat (2) tick();
    check({go_done_o, en_o}, 2'b00, "sleep stop");
    check({sel_o, chs_o, ans_o}, 16'h0FFF, "sleep dflt");
    sleep_i = 1'b0;
    tick();
  endtask

  // Watchdog reckoned at over thirty times the expected run length.
  initial begin
    #1000000;
    fail_count++;
    complete_run();
  end
  task automatic complete_run();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    #2;
    rst_n_i = 1'b1;
    t_reset_pins_refused();
    for (int i = 0; i < 4; i++) begin
      int_en_i = i[0];
      t_convert(i[1:0], 4'(i * 3));
    end
    t_convert(CLKSEL_DIV4, CHS_FIXREF);
    t_midchange();
    t_abort_sleep();
    complete_run();
  end
endmodule
